// ### hw/bsmc_pkg.sv
package bsmc_pkg;
   // ==========================================================================
   // set-point coding
   // ==========================================================================
   localparam int unsigned SP_W         = 6;        // six set-point bits
   localparam int unsigned CODE_W       = 7;        // range bit plus set point
   localparam int unsigned RANGE_POS    = 6;        // range bit within a code
   localparam int unsigned MV_W         = 13;       // millivolt outputs, up to 8191
   localparam logic [12:0] LOW_BASE_MV  = 13'h0190; // 400 mV
   localparam logic [12:0] LOW_STEP_MV  = 13'h0019; // 25 mV
   localparam logic [12:0] HIGH_BASE_MV = 13'h0320; // 800 mV
   localparam logic [12:0] HIGH_STEP_MV = 13'h0032; // 50 mV
   localparam logic [12:0] HIGH_MAX_MV  = 13'h0ce4; // 3300 mV, codes above reserved

   // ==========================================================================
   // reset values
   // ==========================================================================
   localparam logic [5:0] NORMAL_SP_RST  = 6'h00;
   localparam logic [5:0] STANDBY_SP_RST = 6'h00;
   localparam logic [5:0] SLEEP_SP_RST   = 6'h00;
   localparam logic [3:0] SW_MODE_RST    = 4'h0;

   // ==========================================================================
   // switching-mode field encoding (four bits)
   // ==========================================================================
   localparam logic [3:0] SWM_OFF      = 4'h0;
   localparam logic [3:0] SWM_PWM      = 4'h1;
   localparam logic [3:0] SWM_PFM      = 4'h3;
   localparam logic [3:0] SWM_AUTO     = 4'h4;

   // ==========================================================================
   // operating states and switching outputs
   // ==========================================================================
   typedef enum logic [1:0] {
      BSMC_ST_NORMAL  = 2'h0,
      BSMC_ST_STANDBY = 2'h1,
      BSMC_ST_SLEEP   = 2'h2
   } bsmc_opstate_t;

   typedef enum logic [3:0] {
      BSMC_SW_OFF  = 4'h1,
      BSMC_SW_PWM  = 4'h2,
      BSMC_SW_PFM  = 4'h4,
      BSMC_SW_AUTO = 4'h8
   } bsmc_swmode_t;
endpackage : bsmc_pkg

// ### hw/bsmc_code_to_mv.sv
// ============================================================================
// set-point code to millivolt conversion
// ============================================================================
module bsmc_code_to_mv
(
   // code in
   input  wire logic [6:0]  code,
   // result
   output logic      [12:0] mv,
   output logic             reserved
);
   logic [12:0] sp_ext;

   // range bit picks base and step; six low bits scale the step
   always_comb
   begin
      sp_ext   = {7'h00, code[5:0]};
      reserved = 1'b0;
      if (code[bsmc_pkg::RANGE_POS])
      begin
         mv       = 13'(bsmc_pkg::HIGH_BASE_MV + 13'(sp_ext * bsmc_pkg::HIGH_STEP_MV));
         reserved = (mv > bsmc_pkg::HIGH_MAX_MV);
      end
      else
      begin
         mv = 13'(bsmc_pkg::LOW_BASE_MV + 13'(sp_ext * bsmc_pkg::LOW_STEP_MV));
      end
   end
endmodule : bsmc_code_to_mv

// ### hw/bsmc_top.sv
// Operation
// - A programmed config bit of 1 selects termination tracking mode, 0 regulator mode.
// - In termination tracking mode only fixed-frequency pulse-width switching is allowed.
// - In termination tracking mode the reference is half of companion buck A's output.
// - The range-select bit is read-only and comes from the programmed configuration.
// - With range 0 the set point maps to 0.400 V to 1.975 V in 25 mV steps.
// - With range 1 the set point maps to 0.800 V to 3.300 V in 50 mV steps.
// - Three independent six-bit set points serve normal, standby and sleep by state.
// - The initial range bit is copied into the standby and sleep set-point range bits.
// - In regulator mode a four-bit field picks off, pulse-frequency, automatic or pulse-width.
// - Set points and the mode field are written over the two-wire port; range and tracking mode come only from the programmed configuration.
module bsmc_top
(
   // clock and reset
   input  wire logic        sys_clk,
   input  wire logic        rst,
   // programmed configuration, stable from the fuse loader
   input  wire logic        programmed_regulator_config,
   input  wire logic        programmed_range_select,
   // register writes from the management port decoder
   input  wire logic        normal_setpoint_we,
   input  wire logic        standby_setpoint_we,
   input  wire logic        sleep_setpoint_we,
   input  wire logic        switch_mode_we,
   input  wire logic [6:0]  wr_data,
   // operating state from power control
   input  wire logic [1:0]  op_state,
   // companion buck a output in millivolts
   input  wire logic [12:0] companion_buck_a_mv,
   // register read-back
   output logic      [6:0]  output_voltage_register,
   output logic      [6:0]  standby_setpoint,
   output logic      [6:0]  sleep_setpoint,
   output logic      [3:0]  switch_mode_select,
   // regulator control
   output logic             termination_tracking_mode,
   output logic      [3:0]  switching_mode,
   output logic      [12:0] reference_mv,
   output logic             setpoint_reserved
);
   // =========================================================================
   // configuration capture
   // =========================================================================
   logic       tt_mode_q, tt_mode_d;
   logic       range_q, range_d;

   // straps are caught by the clock while reset is high, never by the reset itself
   always_comb
   begin
      tt_mode_d = tt_mode_q;
      range_d   = range_q;
      if (rst)
      begin
         tt_mode_d = programmed_regulator_config;
         range_d   = programmed_range_select;
      end
   end

   always_ff @(posedge sys_clk)
   begin
      tt_mode_q <= tt_mode_d;
      range_q   <= range_d;
   end

   // =========================================================================
   // set-point and mode registers
   // =========================================================================
   logic [5:0] normal_q, normal_d;
   logic [5:0] standby_q, standby_d;
   logic [5:0] sleep_q, sleep_d;
   logic [3:0] swm_q, swm_d;

   // set-point writes keep only the six low bits, mode writes the four low bits; bit 6 of the write is ignored
   always_comb
   begin
      normal_d  = normal_q;
      standby_d = standby_q;
      sleep_d   = sleep_q;
      swm_d     = swm_q;
      if (rst)
      begin
         normal_d  = bsmc_pkg::NORMAL_SP_RST;
         standby_d = bsmc_pkg::STANDBY_SP_RST;
         sleep_d   = bsmc_pkg::SLEEP_SP_RST;
         swm_d     = bsmc_pkg::SW_MODE_RST;
      end
      else
      begin
         if (normal_setpoint_we)
            normal_d = wr_data[5:0];
         if (standby_setpoint_we)
            standby_d = wr_data[5:0];
         if (sleep_setpoint_we)
            sleep_d = wr_data[5:0];
         if (switch_mode_we)
            swm_d = wr_data[3:0];
      end
   end

   always_ff @(posedge sys_clk)
   begin
      normal_q  <= normal_d;
      standby_q <= standby_d;
      sleep_q   <= sleep_d;
      swm_q     <= swm_d;
   end

   // =========================================================================
   // set-point selection and conversion
   // =========================================================================
   logic [5:0]  active_sp;
   logic [12:0] sp_mv;
   logic        sp_res;

   // one range bit shared by all three states
   always_comb
   begin
      unique case (op_state)
         2'(bsmc_pkg::BSMC_ST_STANDBY): active_sp = standby_q;
         2'(bsmc_pkg::BSMC_ST_SLEEP):   active_sp = sleep_q;
         default:                       active_sp = normal_q;
      endcase
   end

   bsmc_code_to_mv u_conv
   (
      .code     ({range_q, active_sp}),
      .mv       (sp_mv),
      .reserved (sp_res)
   );

   // =========================================================================
   // switching mode and reference
   // =========================================================================
   logic [3:0]  swmode_d, swmode_q;
   logic [12:0] ref_d, ref_q;
   logic        res_d, res_q;

   // unknown field codes fall back to pulse-width, the safe continuous mode
   always_comb
   begin
      if (tt_mode_q)
         swmode_d = bsmc_pkg::BSMC_SW_PWM;
      else
      begin
         unique case (swm_q)
            bsmc_pkg::SWM_OFF:  swmode_d = bsmc_pkg::BSMC_SW_OFF;
            bsmc_pkg::SWM_PFM:  swmode_d = bsmc_pkg::BSMC_SW_PFM;
            bsmc_pkg::SWM_AUTO: swmode_d = bsmc_pkg::BSMC_SW_AUTO;
            default:            swmode_d = bsmc_pkg::BSMC_SW_PWM;
         endcase
      end
      if (tt_mode_q)
      begin
         ref_d = {1'b0, companion_buck_a_mv[12:1]};
         res_d = 1'b0;
      end
      else
      begin
         ref_d = sp_mv;
         res_d = sp_res;
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         swmode_q <= bsmc_pkg::BSMC_SW_OFF;
         ref_q    <= '0;
         res_q    <= 1'b0;
      end
      else
      begin
         swmode_q <= swmode_d;
         ref_q    <= ref_d;
         res_q    <= res_d;
      end
   end

   // =========================================================================
   // outputs, all from flip-flops
   // =========================================================================
   assign output_voltage_register   = {range_q, normal_q};
   assign standby_setpoint          = {range_q, standby_q};
   assign sleep_setpoint            = {range_q, sleep_q};
   assign switch_mode_select        = swm_q;
   assign termination_tracking_mode = tt_mode_q;
   assign switching_mode            = swmode_q;
   assign reference_mv              = ref_q;
   assign setpoint_reserved         = res_q;
endmodule : bsmc_top

// ### dv/bsmc_checker.sv
// ============================================================================
// port checker for the set-point and mode control
// ============================================================================
module bsmc_checker
(
   // clock and reset
   input wire logic        sys_clk,
   input wire logic        rst,
   // writes and state
   input wire logic        normal_setpoint_we,
   input wire logic        standby_setpoint_we,
   input wire logic        sleep_setpoint_we,
   input wire logic        switch_mode_we,
   input wire logic [6:0]  wr_data,
   input wire logic [1:0]  op_state,
   input wire logic [12:0] companion_buck_a_mv,
   // outputs watched
   input wire logic [6:0]  output_voltage_register,
   input wire logic [6:0]  standby_setpoint,
   input wire logic [6:0]  sleep_setpoint,
   input wire logic [3:0]  switch_mode_select,
   input wire logic        termination_tracking_mode,
   input wire logic [3:0]  switching_mode,
   input wire logic [12:0] reference_mv,
   input wire logic        setpoint_reserved
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [6:0]  sel_code;
   logic [12:0] exp_mv;
   logic [3:0]  exp_sw;

   // expected reference and switching from the read-back registers
   always_comb
   begin
      case (op_state)
         2'h1:    sel_code = standby_setpoint;
         2'h2:    sel_code = sleep_setpoint;
         default: sel_code = output_voltage_register;
      endcase
      exp_mv = sel_code[6] ? 13'h0320 + 13'(sel_code[5:0]) * 13'h0032
                           : 13'h0190 + 13'(sel_code[5:0]) * 13'h0019;
      case (switch_mode_select)
         4'h0:    exp_sw = 4'h1;
         4'h3:    exp_sw = 4'h4;
         4'h4:    exp_sw = 4'h8;
         default: exp_sw = 4'h2;
      endcase
   end

   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);

   track_pwm_a: assert property (!$past(rst) && !$past(rst, 2) &&
      termination_tracking_mode |-> switching_mode == 4'h2) else $error("tracking not pwm");
   track_ref_a: assert property (termination_tracking_mode |=>
      reference_mv == $past(companion_buck_a_mv) >> 1) else $error("tracking reference wrong");
   normal_wr_a: assert property (normal_setpoint_we |=> output_voltage_register ==
      {$past(output_voltage_register[6]), $past(wr_data[5:0])}) else $error("normal write wrong");
   stby_wr_a: assert property (standby_setpoint_we |=>
      standby_setpoint[5:0] == $past(wr_data[5:0])) else $error("standby write wrong");
   sleep_wr_a: assert property (sleep_setpoint_we |=>
      sleep_setpoint[5:0] == $past(wr_data[5:0])) else $error("sleep write wrong");
   range_copy_a: assert property (standby_setpoint[6] == output_voltage_register[6] &&
      sleep_setpoint[6] == output_voltage_register[6]) else $error("range bits differ");
   mode_wr_a: assert property (switch_mode_we |=>
      switch_mode_select == $past(wr_data[3:0])) else $error("mode write wrong");
   reg_mode_a: assert property (!termination_tracking_mode |=>
      switching_mode == $past(exp_sw)) else $error("switching mode wrong");
   reg_ref_a: assert property (!termination_tracking_mode &&
      !(sel_code[6] && sel_code[5:0] > 6'h32) |=> reference_mv == $past(exp_mv))
      else $error("regulator reference wrong");
   res_flag_a: assert property (1'b1 |=> setpoint_reserved ==
      $past(!termination_tracking_mode && sel_code[6] && sel_code[5:0] > 6'h32))
      else $error("reserved flag wrong");

   // main scenarios reached
   cover property (termination_tracking_mode ##1 switch_mode_we);
   cover property (op_state == 2'h2 && sleep_setpoint[6]);
   cover property (standby_setpoint_we && sleep_setpoint_we);
   cover property (setpoint_reserved);
endmodule : bsmc_checker

bind bsmc_top bsmc_checker bsmc_checker_inst (.*);

// ### dv/tb_bsmc_top.sv
module tb_bsmc_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic        sys_clk, rst, cfg, rng, termination_tracking_mode, setpoint_reserved;
   logic [3:0]  we, switch_mode_select, switching_mode;
   logic [6:0]  wr_data, output_voltage_register, standby_setpoint, sleep_setpoint;
   logic [1:0]  op_state;
   logic [12:0] comp_mv, reference_mv;
   logic [3:0]  mc [5] = '{4'h0, 4'h1, 4'h3, 4'h4, 4'h5};
   logic [3:0]  ms [5] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h2};
   logic [12:0] rv [4] = '{13'h0320, 13'h07b7, 13'h0271, 13'h0320};
   int          errors = 0;
   int          compares = 0;

   bsmc_top bsmc_top_inst (.sys_clk(sys_clk), .rst(rst), .programmed_regulator_config(cfg),
      .programmed_range_select(rng), .normal_setpoint_we(we[3]), .standby_setpoint_we(we[2]),
      .sleep_setpoint_we(we[1]), .switch_mode_we(we[0]), .wr_data(wr_data), .op_state(op_state),
      .companion_buck_a_mv(comp_mv), .output_voltage_register(output_voltage_register),
      .standby_setpoint(standby_setpoint), .sleep_setpoint(sleep_setpoint),
      .switch_mode_select(switch_mode_select),
      .termination_tracking_mode(termination_tracking_mode),
      .switching_mode(switching_mode), .reference_mv(reference_mv),
      .setpoint_reserved(setpoint_reserved));

   // ==========================================================================
   // access tasks
   // ==========================================================================
   task automatic chk(input string n, input logic [12:0] e, input logic [12:0] g);
      compares++;
      if (g !== e)
      begin
         errors++;
         $display("unexpected %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   // strobes go low a full edge later so back-to-back calls never collide
   task automatic wr(input logic [3:0] m, input logic [6:0] d);
      @(posedge sys_clk);
      we      <= m;
      wr_data <= d;
      @(posedge sys_clk);
      we      <= 4'h0;
   endtask : wr
   // reference lags the write by two edges
   task automatic settle;
      repeat (2) @(posedge sys_clk);
      #1;
   endtask : settle
   task automatic start(input logic c, input logic r);
      @(posedge sys_clk);
      rst <= 1'b1;
      cfg <= c;
      rng <= r;
      repeat (4) @(posedge sys_clk);
      rst <= 1'b0;
      settle();
      chk("tracking", 13'(c), 13'(termination_tracking_mode));
      chk("range", 13'({r, r, r}), 13'({output_voltage_register[6], standby_setpoint[6],
         sleep_setpoint[6]}));
   endtask : start
   task automatic summarize;
      $display("compares %0d errors %0d", compares, errors);
      if (errors == 0 && compares > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : summarize

   // ==========================================================================
   // clock, watchdog and tests
   // ==========================================================================
   initial
   begin
      sys_clk = 1'b0;
      forever #20 sys_clk = ~sys_clk;
   end
   // the tests need about ninety cycles
   initial
   begin
      repeat (3000) @(posedge sys_clk);
      errors++;
      summarize();
   end
   initial
   begin
      {rst, cfg, rng, we, wr_data, op_state, comp_mv} <= {1'b1, 15'h0, 13'h05dd};
      start(1'b0, 1'b0);
      wr(4'h8, 7'h50);
      settle();
      chk("normal", 13'h0010, 13'(output_voltage_register));
      chk("reference", 13'h0320, reference_mv);
      // one write loads standby and sleep together, then sleep alone is rewritten
      wr(4'h6, 7'h3f);
      wr(4'h2, 7'h09);
      settle();
      chk("standby", 13'h003f, 13'(standby_setpoint));
      chk("sleep", 13'h0009, 13'(sleep_setpoint));
      for (int i = 0; i < 4; i++)
      begin
         @(posedge sys_clk);
         op_state <= 2'(i + 1);
         settle();
         chk("state reference", rv[(i + 1) % 4], reference_mv);
      end
      for (int i = 0; i < 5; i++)
      begin
         wr(4'h1, 7'(mc[i]));
         settle();
         chk("switching", 13'(ms[i]), 13'(switching_mode));
      end
      $display("regulator low range done");
      start(1'b0, 1'b1);
      wr(4'h8, 7'h32);
      settle();
      chk("normal", 13'h0072, 13'(output_voltage_register));
      chk("reference", 13'h0ce4, reference_mv);
      chk("reserved", 13'h0000, 13'(setpoint_reserved));
      // sleep uses the copied range bit as well
      wr(4'h2, 7'h18);
      @(posedge sys_clk);
      op_state <= 2'h2;
      settle();
      chk("sleep", 13'h0058, 13'(sleep_setpoint));
      chk("sleep reference", 13'h07d0, reference_mv);
      @(posedge sys_clk);
      op_state <= 2'h0;
      // first code past the top of the high range
      wr(4'h8, 7'h33);
      settle();
      chk("reserved", 13'h0001, 13'(setpoint_reserved));
      $display("regulator high range done");
      start(1'b1, 1'b0);
      wr(4'h1, 7'h03);
      settle();
      chk("mode field", 13'h0003, 13'(switch_mode_select));
      chk("switching", 13'h0002, 13'(switching_mode));
      chk("reference", 13'h02ee, reference_mv);
      chk("reserved", 13'h0000, 13'(setpoint_reserved));
      @(posedge sys_clk);
      comp_mv <= 13'h0ce4;
      settle();
      chk("reference", 13'h0672, reference_mv);
      // a low set point is legal here and must not move the tracking reference
      wr(4'h8, 7'h04);
      settle();
      chk("normal", 13'h0004, 13'(output_voltage_register));
      chk("reference", 13'h0672, reference_mv);
      $display("tracking mode done");
      summarize();
   end
endmodule : tb_bsmc_top
